// ### hdl/acr_defs.svh
// register offsets, field positions, reset values and oversampling ratios
`ifndef ACR_DEFS_SVH
`define ACR_DEFS_SVH

`define ACR_ADDR_ANALOG_CONTROL     8'h01
`define ACR_ADDR_OPERATING_MODE     8'h02
`define ACR_ADDR_OUTPUT_SOURCE      8'h03

`define ACR_RST_ANALOG_CONTROL      8'h00
`define ACR_RST_OPERATING_MODE      8'h00
`define ACR_RST_OUTPUT_SOURCE       8'h81

// analog control fields
`define ACR_AC_FRAME_START          7
`define ACR_AC_GROUND_CAL           6
`define ACR_AC_ANALOG_PD            5
`define ACR_AC_DIGITAL_PD           4
`define ACR_AC_TEST                 3
`define ACR_AC_USED_MASK            8'hF8

// operating mode fields
`define ACR_MD_OVERSAMPLE           7
`define ACR_MD_CALIBRATE            6
`define ACR_MD_SIGN_CHANGE          5
`define ACR_MD_ROUTING              4
`define ACR_MD_HIGHPASS_OFF         3
`define ACR_MD_SLAVE                2
`define ACR_MD_FORMAT               1
`define ACR_MD_MUTE                 0

// output source select fields
`define ACR_OS_P1_FULL              7
`define ACR_OS_P2_FULL              6
`define ACR_OS_P1_SHAPED            5
`define ACR_OS_P2_SHAPED            4
`define ACR_OS_WIDTH18              3
`define ACR_OS_WIDTH20              2
`define ACR_OS_P1_SHORT             1
`define ACR_OS_P2_SHORT             0

// oversampling ratios
`define ACR_RATIO_HIGH              8'd128
`define ACR_RATIO_LOW               8'd64

`endif

// ### hdl/acr_pkg.sv
// types shared by the control register bank
package acr_pkg;
  // source chosen for a serial output
  typedef enum logic [1:0] {
    ACR_SRC_FULL    = 2'b00,
    ACR_SRC_SHAPED  = 2'b01,
    ACR_SRC_SHORT   = 2'b11,
    ACR_SRC_NONE    = 2'b10
  } acr_src_t;

  typedef enum logic [1:0] {
    ACR_CAL_IDLE = 2'b00,
    ACR_CAL_RUN  = 2'b01,
    ACR_CAL_DONE = 2'b11
  } acr_cal_t;
endpackage : acr_pkg

// ### hdl/acr_regs.sv
// control register bank of the stereo audio converter
`timescale 1ns/1ps
`default_nettype none
`include "acr_defs.svh"

// Functional notes
// R1: frame start write sends pulse, self-clears
// R2: ground calibration ties modulator to common-mode
// R3: analog power-down bit powers analog section down
// R4: digital power-down bit powers modulator digital down
// R5: host writes test bit zero always
// R6: oversample bit selects 128 else 64
// R7: calibration bit starts, clears on completion
// R8: sign change swaps input paths, both channels
// R9: routing clear: each port own source
// R10: routing set: port one left, two right
// R11: highpass-disable bit bypasses highpass filter
// R12: calibration completion re-enables highpass filter
// R13: master drives clocks, slave receives them
// R14: slave bit ignored in external input modes
// R15: format bit selects i2s else left-justified
// R16: mute forces zero data on both outputs
// R17: port two full bit sends 24-bit
// R18: host clears port two full first
// R19: port one shaped only if alone
// R20: port two conflict selects short delay
// R21: short delay path through highpass unless disabled
// R22: analog control bits 2..0 read zero
// R23: frame pulse one cycle, clear next
module acr_regs
  import acr_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  // register port from the serial control decoder
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  output logic      [DATA_W-1:0] reg_rdata,
  output logic                   reg_rvalid,
  // status from the converter core
  input  wire logic              cal_done,
  input  wire logic              ext_input_mode,
  // analog and modulator controls
  output logic                   frame_start_pulse,
  output logic                   ground_cal_en,
  output logic                   analog_pd,
  output logic                   modulator_digital_pd,
  output logic                   factory_test_bit,
  output logic                   sign_change_en,
  // rate and filter controls
  output logic                   oversample_ratio_select,
  output logic [7:0]             oversample_ratio,
  output logic                   cal_start_pulse,
  output logic                   cal_busy,
  output logic                   highpass_bypass,
  output logic                   short_delay_highpass,
  // serial port controls
  output logic                   clocks_driven,
  output logic                   serial_format_select,
  output logic                   mute_outputs,
  output logic                   channel_routing_select,
  output logic [1:0]             serial_out_one_left_src,
  output logic [1:0]             serial_out_one_right_src,
  output logic [1:0]             serial_out_two_left_src,
  output logic [1:0]             serial_out_two_right_src,
  output logic                   shaped_width_18_select,
  output logic                   shaped_width_20_select
);

  // *********************************************************
  // elaboration checks
  // *********************************************************
  if (DATA_W != 8) begin : g_bad_data
    $error("acr_regs supports only 8-bit data");
  end
  if (ADDR_W < 2) begin : g_bad_addr
    $error("acr_regs needs at least 2 address bits");
  end

  // *********************************************************
  // reset release
  // *********************************************************
  logic rst_sync1_q;
  logic rst_n_q;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync1_q <= 1'b0;
      rst_n_q     <= 1'b0;
    end else begin
      rst_sync1_q <= 1'b1;
      rst_n_q     <= rst_sync1_q;
    end
  end

  // *********************************************************
  // address decode
  // *********************************************************
  logic hit_ac;
  logic hit_md;
  logic hit_os;

  assign hit_ac = (reg_addr == ADDR_W'(`ACR_ADDR_ANALOG_CONTROL));
  assign hit_md = (reg_addr == ADDR_W'(`ACR_ADDR_OPERATING_MODE));
  assign hit_os = (reg_addr == ADDR_W'(`ACR_ADDR_OUTPUT_SOURCE));

  // *********************************************************
  // analog control register
  // *********************************************************
  logic [7:0] ac_q;
  logic       fs_pulse_q;

  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ac_q <= `ACR_RST_ANALOG_CONTROL;
    end else if (reg_wr && hit_ac) begin
      // low bits are not stored at all
      ac_q <= reg_wdata & `ACR_AC_USED_MASK; // [R22]
    end else if (fs_pulse_q) begin
      // the bit drops the cycle after the pulse went out
      ac_q[`ACR_AC_FRAME_START] <= 1'b0; // [R1] [R23]
    end
  end

  // single-cycle pulse; a bit held by a rewrite repeats it after a one-cycle gap
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fs_pulse_q <= 1'b0;
    end else begin
      fs_pulse_q <= ac_q[`ACR_AC_FRAME_START] && !fs_pulse_q; // [R23]
    end
  end

  // *********************************************************
  // operating mode register
  // *********************************************************
  logic [7:0] md_q;
  logic       cal_pulse_q;
  acr_cal_t   cal_state_q;

  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cal_state_q <= ACR_CAL_IDLE;
    end else begin
      case (cal_state_q)
        ACR_CAL_IDLE: begin
          if (reg_wr && hit_md && reg_wdata[`ACR_MD_CALIBRATE]) begin
            cal_state_q <= ACR_CAL_RUN; // [R7]
          end
        end
        ACR_CAL_RUN: begin
          if (cal_done) begin
            cal_state_q <= ACR_CAL_DONE;
          end
        end
        ACR_CAL_DONE: begin
          cal_state_q <= ACR_CAL_IDLE;
        end
        default: begin
          cal_state_q <= ACR_CAL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      md_q <= `ACR_RST_OPERATING_MODE;
    end else begin
      if (reg_wr && hit_md) begin
        md_q <= reg_wdata;
        // a running calibration cannot be cancelled by software
        if (cal_state_q == ACR_CAL_RUN) begin
          md_q[`ACR_MD_CALIBRATE] <= 1'b1;
        end
      end
      if (cal_state_q == ACR_CAL_RUN && cal_done) begin
        md_q[`ACR_MD_CALIBRATE]    <= 1'b0; // [R7]
        md_q[`ACR_MD_HIGHPASS_OFF] <= 1'b0; // [R12]
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cal_pulse_q <= 1'b0;
    end else begin
      cal_pulse_q <= (cal_state_q == ACR_CAL_IDLE) && reg_wr && hit_md
                     && reg_wdata[`ACR_MD_CALIBRATE]; // [R7]
    end
  end

  // *********************************************************
  // output source select register
  // *********************************************************
  logic [7:0] os_q;

  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      os_q <= `ACR_RST_OUTPUT_SOURCE;
    end else if (reg_wr && hit_os) begin
      // the host must clear port two full first; the decoder copes anyway
      os_q <= reg_wdata; // [R18]
    end
  end

  // *********************************************************
  // read port
  // *********************************************************
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      reg_rdata  <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        if (hit_ac) begin
          reg_rdata <= ac_q; // [R22]
        end else if (hit_md) begin
          reg_rdata <= md_q;
        end else if (hit_os) begin
          reg_rdata <= os_q;
        end else begin
          reg_rdata <= '0;
        end
      end
    end
  end

  // *********************************************************
  // source decode
  // *********************************************************
  acr_src_t src_one;
  acr_src_t src_two;
  logic     one_shaped_ok;

  acr_src_decode #(
    .SHORT_ON_CONFLICT (1'b0)
  ) u_dec_one (
    .full_bit   (os_q[`ACR_OS_P1_FULL]),
    .shaped_bit (os_q[`ACR_OS_P1_SHAPED]),
    .short_bit  (os_q[`ACR_OS_P1_SHORT]),
    .src        (src_one)
  );

  acr_src_decode #(
    .SHORT_ON_CONFLICT (1'b1)
  ) u_dec_two (
    .full_bit   (os_q[`ACR_OS_P2_FULL]),
    .shaped_bit (os_q[`ACR_OS_P2_SHAPED]),
    .short_bit  (os_q[`ACR_OS_P2_SHORT]),
    .src        (src_two) // [R17] [R20]
  );

  // port one shaped output needs every other port one bit clear
  assign one_shaped_ok = os_q[`ACR_OS_P1_SHAPED]
                         && !os_q[`ACR_OS_P1_FULL]
                         && !os_q[`ACR_OS_P1_SHORT]; // [R19]

  acr_src_t one_eff;
  always_comb begin
    if (src_one == ACR_SRC_SHAPED && !one_shaped_ok) begin
      one_eff = ACR_SRC_NONE;
    end else begin
      one_eff = src_one; // [R19]
    end
  end

  // *********************************************************
  // registered control outputs
  // *********************************************************
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      frame_start_pulse    <= 1'b0;
      ground_cal_en        <= 1'b0;
      analog_pd            <= 1'b0;
      modulator_digital_pd <= 1'b0;
      factory_test_bit     <= 1'b0;
      sign_change_en       <= 1'b0;
    end else begin
      frame_start_pulse    <= ac_q[`ACR_AC_FRAME_START]
                              && !fs_pulse_q; // [R1] [R23]
      ground_cal_en        <= ac_q[`ACR_AC_GROUND_CAL]; // [R2]
      analog_pd            <= ac_q[`ACR_AC_ANALOG_PD]; // [R3]
      modulator_digital_pd <= ac_q[`ACR_AC_DIGITAL_PD]; // [R4]
      // passed through as written; software keeps it zero
      factory_test_bit     <= ac_q[`ACR_AC_TEST]; // [R5]
      sign_change_en       <= md_q[`ACR_MD_SIGN_CHANGE]; // [R8]
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      oversample_ratio_select <= 1'b0;
      oversample_ratio        <= `ACR_RATIO_LOW;
      cal_start_pulse         <= 1'b0;
      cal_busy                <= 1'b0;
      highpass_bypass         <= 1'b0;
      short_delay_highpass    <= 1'b1;
    end else begin
      oversample_ratio_select <= md_q[`ACR_MD_OVERSAMPLE];
      oversample_ratio        <= md_q[`ACR_MD_OVERSAMPLE]
                                 ? `ACR_RATIO_HIGH
                                 : `ACR_RATIO_LOW; // [R6]
      cal_start_pulse         <= cal_pulse_q; // [R7]
      cal_busy                <= md_q[`ACR_MD_CALIBRATE];
      highpass_bypass         <= md_q[`ACR_MD_HIGHPASS_OFF]; // [R11]
      short_delay_highpass    <= !md_q[`ACR_MD_HIGHPASS_OFF]; // [R21]
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      clocks_driven          <= 1'b1;
      serial_format_select   <= 1'b0;
      mute_outputs           <= 1'b0;
      channel_routing_select <= 1'b0;
      shaped_width_18_select <= 1'b0;
      shaped_width_20_select <= 1'b0;
    end else begin
      // external input modes force master clocking
      clocks_driven          <= ext_input_mode
                                || !md_q[`ACR_MD_SLAVE]; // [R13] [R14]
      serial_format_select   <= md_q[`ACR_MD_FORMAT]; // [R15]
      mute_outputs           <= md_q[`ACR_MD_MUTE]; // [R16]
      channel_routing_select <= md_q[`ACR_MD_ROUTING];
      shaped_width_18_select <= os_q[`ACR_OS_WIDTH18];
      shaped_width_20_select <= os_q[`ACR_OS_WIDTH20];
    end
  end

  // muted ports carry no source at all
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      serial_out_one_left_src  <= ACR_SRC_FULL;
      serial_out_one_right_src <= ACR_SRC_FULL;
      serial_out_two_left_src  <= ACR_SRC_SHORT;
      serial_out_two_right_src <= ACR_SRC_SHORT;
    end else if (md_q[`ACR_MD_MUTE]) begin
      serial_out_one_left_src  <= ACR_SRC_NONE; // [R16]
      serial_out_one_right_src <= ACR_SRC_NONE;
      serial_out_two_left_src  <= ACR_SRC_NONE;
      serial_out_two_right_src <= ACR_SRC_NONE;
    end else if (md_q[`ACR_MD_ROUTING]) begin
      // port one: left of both; port two: right of both
      serial_out_one_left_src  <= one_eff; // [R10]
      serial_out_one_right_src <= src_two;
      serial_out_two_left_src  <= one_eff;
      serial_out_two_right_src <= src_two;
    end else begin
      serial_out_one_left_src  <= one_eff; // [R9]
      serial_out_one_right_src <= one_eff;
      serial_out_two_left_src  <= src_two;
      serial_out_two_right_src <= src_two;
    end
  end

endmodule : acr_regs
`default_nettype wire

// ### hdl/acr_src_decode.sv
// per-port output source decoder
`timescale 1ns/1ps
`default_nettype none
module acr_src_decode
  import acr_pkg::*;
#(
  parameter bit SHORT_ON_CONFLICT = 1'b0
) (
  // source bits of one port
  input  wire logic     full_bit,
  input  wire logic     shaped_bit,
  input  wire logic     short_bit,
  // decoded source
  output acr_src_t      src
);
  logic [1:0] cnt;
  always_comb begin
    cnt = 2'(full_bit) + 2'(shaped_bit) + 2'(short_bit);
    if (cnt > 2'd1) begin
      // full precision wins where the port has no conflict fallback
      src = SHORT_ON_CONFLICT ? ACR_SRC_SHORT : ACR_SRC_FULL;
    end else if (full_bit) begin
      src = ACR_SRC_FULL;
    end else if (shaped_bit) begin
      src = ACR_SRC_SHAPED;
    end else if (short_bit) begin
      src = ACR_SRC_SHORT;
    end else begin
      src = ACR_SRC_NONE;
    end
  end
endmodule : acr_src_decode
`default_nettype wire

// ### sim/acr_host_model.sv
// host microcontroller model driving the register port
`timescale 1ns/1ps
`default_nettype none
`include "acr_defs.svh"
module acr_host_model (
  // clock
  input  wire logic       clk_sys,
  // register port toward the bank
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  // ****************************************
  // bus cycles
  // ****************************************
  logic [7:0] src_q = `ACR_RST_OUTPUT_SOURCE;
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // released lines show the inverse so stale values never pass
  task automatic put(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk_sys);
    reg_addr = addr;
    reg_wdata = data;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_addr = ~addr;
    reg_wdata = ~data;
  endtask : put
  task automatic write(input logic [7:0] addr, input logic [7:0] data);
    logic [7:0] d;
    d = data;
    if (addr == `ACR_ADDR_ANALOG_CONTROL) d[3] = 1'b0;
    if (addr == `ACR_ADDR_OUTPUT_SOURCE) begin
      if (src_q[6] && !d[6] && (d[4] || d[0]))
        put(addr, src_q & 8'hBF);
      src_q = d;
    end
    put(addr, d);
  endtask : write
  task automatic read(input logic [7:0] addr, output logic [7:0] data);
    int n;
    @(negedge clk_sys);
    reg_addr = addr;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    reg_addr = ~addr;
    n = 0;
    while (reg_rvalid !== 1'b1 && n < 8) begin
      @(negedge clk_sys);
      n++;
    end
    data = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
  endtask : read
endmodule : acr_host_model
`default_nettype wire

// ### sim/acr_regs_sva.sv
// assertions on the control register bank ports
`timescale 1ns/1ps
`default_nettype none
`include "acr_defs.svh"
module acr_regs_sva
  import acr_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8
) (
  // clock and reset
  input wire logic              clk_sys,
  input wire logic              arst_n,
  // register port
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic              reg_rvalid,
  // core status
  input wire logic              cal_done,
  input wire logic              ext_input_mode,
  // controls
  input wire logic              frame_start_pulse,
  input wire logic              ground_cal_en,
  input wire logic              analog_pd,
  input wire logic              modulator_digital_pd,
  input wire logic              sign_change_en,
  input wire logic              oversample_ratio_select,
  input wire logic [7:0]        oversample_ratio,
  input wire logic              cal_start_pulse,
  input wire logic              cal_busy,
  input wire logic              highpass_bypass,
  input wire logic              short_delay_highpass,
  input wire logic              clocks_driven,
  input wire logic              serial_format_select,
  input wire logic              mute_outputs,
  input wire logic              channel_routing_select,
  input wire logic [1:0]        serial_out_one_left_src,
  input wire logic [1:0]        serial_out_one_right_src,
  input wire logic [1:0]        serial_out_two_left_src,
  input wire logic [1:0]        serial_out_two_right_src
);
  // ****************************************
  // helpers and properties
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // write data two edges back, lined up with the control outputs
  logic [DATA_W-1:0] wd1_q;
  logic [DATA_W-1:0] wd2_q;
  logic              wr_ac;
  logic              wr_md;
  always_ff @(posedge clk_sys) begin
    wd1_q <= reg_wdata;
    wd2_q <= wd1_q;
  end
  assign wr_ac = reg_wr && reg_addr == `ACR_ADDR_ANALOG_CONTROL;
  assign wr_md = reg_wr && reg_addr == `ACR_ADDR_OPERATING_MODE;

  frame_pulse_a: assert property (
    wr_ac && reg_wdata[7] |-> ##2 frame_start_pulse ##1 !frame_start_pulse)
    else $error("frame start pulse wrong");
  analog_copy_a: assert property (
    wr_ac |-> ##2 {ground_cal_en, analog_pd, modulator_digital_pd}
      == wd2_q[6:4])
    else $error("analog controls do not follow write");
  unused_zero_a: assert property (
    reg_rd && reg_addr == `ACR_ADDR_ANALOG_CONTROL
      |=> reg_rvalid && reg_rdata[2:0] == 3'b000)
    else $error("analog control low bits not zero");
  mode_copy_a: assert property (
    wr_md |-> ##2 {oversample_ratio_select, sign_change_en,
      channel_routing_select, serial_format_select, mute_outputs}
      == {wd2_q[7], wd2_q[5:4], wd2_q[1:0]})
    else $error("mode controls do not follow write");
  ratio_value_a: assert property (
    oversample_ratio == (oversample_ratio_select ? `ACR_RATIO_HIGH
      : `ACR_RATIO_LOW))
    else $error("oversampling ratio wrong");
  highpass_pair_a: assert property (
    short_delay_highpass == !highpass_bypass)
    else $error("short delay highpass path wrong");
  mute_none_a: assert property (
    mute_outputs |-> serial_out_one_left_src == ACR_SRC_NONE
      && serial_out_one_right_src == ACR_SRC_NONE
      && serial_out_two_left_src == ACR_SRC_NONE
      && serial_out_two_right_src == ACR_SRC_NONE)
    else $error("mute does not silence all lanes");
  routing_pair_a: assert property (
    channel_routing_select && !mute_outputs
      |-> serial_out_one_left_src == serial_out_two_left_src
      && serial_out_one_right_src == serial_out_two_right_src)
    else $error("channel routing lanes wrong");
  cal_start_a: assert property (
    wr_md && reg_wdata[6] && !cal_busy && !cal_done
      |-> ##2 cal_start_pulse && cal_busy ##1 !cal_start_pulse)
    else $error("calibration start wrong");
  cal_end_a: assert property (
    cal_busy && cal_done |-> ##2 !cal_busy && !highpass_bypass)
    else $error("calibration end wrong");
  ext_master_a: assert property (
    ext_input_mode [*2] |-> clocks_driven)
    else $error("external input mode not master");
endmodule : acr_regs_sva
`default_nettype wire

// ### sim/adc_control_registers_test.sv
// self-checking bench for the control register bank
`timescale 1ns/1ps
`default_nettype none
`include "acr_defs.svh"
module adc_control_registers_test
  import acr_pkg::*;
;
  // ****************************************
  // bench
  // ****************************************
  logic clk_sys = 1'b0;
  logic arst_n, cal_done, ext_input_mode, reg_wr, reg_rd, reg_rvalid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, oversample_ratio, srcs;
  logic frame_start_pulse, ground_cal_en, analog_pd, modulator_digital_pd;
  logic factory_test_bit, sign_change_en, oversample_ratio_select;
  logic cal_start_pulse, cal_busy, highpass_bypass, short_delay_highpass;
  logic clocks_driven, serial_format_select, mute_outputs;
  logic channel_routing_select, shaped_width_18_select;
  logic shaped_width_20_select;
  logic [1:0] serial_out_one_left_src, serial_out_one_right_src;
  logic [1:0] serial_out_two_left_src, serial_out_two_right_src;
  logic [7:0] mvec;
  int err_total = 0;
  int tests_run = 0;
  logic [7:0] srcv [5] = '{8'h21, 8'hB0, 8'h42, 8'h1F, 8'h42};
  logic [3:0] srce [5] = '{4'b0111, 4'b0001, 4'b1100, 4'b1111, 4'b1100};

  always #12.5 clk_sys = ~clk_sys;
  assign srcs = {serial_out_one_left_src, serial_out_one_right_src,
                 serial_out_two_left_src, serial_out_two_right_src};
  assign mvec = {oversample_ratio_select, sign_change_en,
                 channel_routing_select, highpass_bypass, !clocks_driven,
                 serial_format_select, mute_outputs, 1'b0};

  acr_regs dut_u (.clk_sys, .arst_n, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .reg_rvalid, .cal_done, .ext_input_mode,
    .frame_start_pulse, .ground_cal_en, .analog_pd, .modulator_digital_pd,
    .factory_test_bit, .sign_change_en, .oversample_ratio_select,
    .oversample_ratio, .cal_start_pulse, .cal_busy, .highpass_bypass,
    .short_delay_highpass, .clocks_driven, .serial_format_select,
    .mute_outputs, .channel_routing_select, .serial_out_one_left_src,
    .serial_out_one_right_src, .serial_out_two_left_src,
    .serial_out_two_right_src, .shaped_width_18_select,
    .shaped_width_20_select);
  acr_host_model host_u (.clk_sys, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .reg_rvalid);

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] v;
    host_u.read(addr, v);
    check(v, exp);
  endtask : rd_chk
  task automatic wr_settle(input logic [7:0] addr, input logic [7:0] d);
    host_u.write(addr, d);
    repeat (2) @(negedge clk_sys);
  endtask : wr_settle
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    summarize();
  end

  initial begin
    arst_n = 1'b0;
    cal_done = 1'b0;
    ext_input_mode = 1'b0;
    repeat (20) @(negedge clk_sys);
    arst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    rd_chk(`ACR_ADDR_ANALOG_CONTROL, `ACR_RST_ANALOG_CONTROL);
    rd_chk(`ACR_ADDR_OPERATING_MODE, `ACR_RST_OPERATING_MODE);
    rd_chk(`ACR_ADDR_OUTPUT_SOURCE, `ACR_RST_OUTPUT_SOURCE);
    check(oversample_ratio, `ACR_RATIO_LOW);
    check(srcs, 8'b0000_1111);
    $display("test 1 done");
    host_u.write(`ACR_ADDR_ANALOG_CONTROL, 8'hFF);
    @(negedge clk_sys);
    check({7'd0, frame_start_pulse}, 8'h01);
    @(negedge clk_sys);
    check({7'd0, frame_start_pulse}, 8'h00);
    check({4'd0, ground_cal_en, analog_pd, modulator_digital_pd,
           factory_test_bit}, 8'h0E);
    rd_chk(`ACR_ADDR_ANALOG_CONTROL, 8'h70);
    wr_settle(`ACR_ADDR_ANALOG_CONTROL, 8'h50);
    check({4'd0, ground_cal_en, analog_pd, modulator_digital_pd,
           factory_test_bit}, 8'h0A);
    $display("test 2 done");
    for (int i = 0; i < 8; i++) begin
      if (i != 6) begin
        wr_settle(`ACR_ADDR_OPERATING_MODE, 8'h01 << i);
        rd_chk(`ACR_ADDR_OPERATING_MODE, 8'h01 << i);
        check(mvec, (8'h01 << i) & 8'hBF ? 8'h01 << i << (i < 6) : 8'h00);
        check(oversample_ratio, i == 7 ? `ACR_RATIO_HIGH
              : `ACR_RATIO_LOW);
        check(srcs, i == 0 ? 8'b1010_1010 : i == 4 ? 8'b0011_0011
              : 8'b0000_1111);
      end
    end
    $display("test 3 done");
    host_u.write(`ACR_ADDR_OPERATING_MODE, 8'h48);
    @(negedge clk_sys);
    check({7'd0, cal_start_pulse}, 8'h01);
    @(negedge clk_sys);
    check({6'd0, cal_busy, highpass_bypass}, 8'h03);
    rd_chk(`ACR_ADDR_OPERATING_MODE, 8'h48);
    cal_done = 1'b1;
    @(negedge clk_sys);
    cal_done = 1'b0;
    repeat (2) @(negedge clk_sys);
    check({6'd0, cal_busy, highpass_bypass}, 8'h00);
    rd_chk(`ACR_ADDR_OPERATING_MODE, 8'h00);
    $display("test 4 done");
    for (int i = 0; i < 5; i++) begin
      wr_settle(`ACR_ADDR_OUTPUT_SOURCE, srcv[i]);
      rd_chk(`ACR_ADDR_OUTPUT_SOURCE, srcv[i]);
      check(srcs, {{2{srce[i][3:2]}}, {2{srce[i][1:0]}}});
      check({6'd0, shaped_width_18_select, shaped_width_20_select},
            {6'd0, srcv[i][3:2]});
    end
    wr_settle(`ACR_ADDR_OPERATING_MODE, 8'h10);
    check(srcs, 8'b1100_1100);
    $display("test 5 done");
    wr_settle(8'h00, 8'hFF);
    wr_settle(8'h04, 8'hFF);
    rd_chk(8'h00, 8'h00);
    rd_chk(8'h04, 8'h00);
    rd_chk(`ACR_ADDR_ANALOG_CONTROL, 8'h50);
    $display("test 6 done");
    wr_settle(`ACR_ADDR_OPERATING_MODE, 8'h04);
    check({7'd0, clocks_driven}, 8'h00);
    ext_input_mode = 1'b1;
    repeat (2) @(negedge clk_sys);
    check({7'd0, clocks_driven}, 8'h01);
    ext_input_mode = 1'b0;
    repeat (2) @(negedge clk_sys);
    check({7'd0, clocks_driven}, 8'h00);
    $display("test 7 done");
    summarize();
  end
endmodule : adc_control_registers_test

bind acr_regs acr_regs_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk_u (
  .clk_sys, .arst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
  .reg_rvalid, .cal_done, .ext_input_mode, .frame_start_pulse,
  .ground_cal_en, .analog_pd, .modulator_digital_pd, .sign_change_en,
  .oversample_ratio_select, .oversample_ratio, .cal_start_pulse,
  .cal_busy, .highpass_bypass, .short_delay_highpass, .clocks_driven,
  .serial_format_select, .mute_outputs, .channel_routing_select,
  .serial_out_one_left_src, .serial_out_one_right_src,
  .serial_out_two_left_src, .serial_out_two_right_src);
`default_nettype wire
